// ### include/mitd_defines.svh
/*
 * Constants of the instruction length and timing decoder: widths, opcodes,
 * lengths, cycle counts and address-space limits.
 * Assumes it is included by bare name from the decoder.
 */
`ifndef MITD_DEFINES_SVH
`define MITD_DEFINES_SVH

`define MITD_LEN_W        3
`define MITD_CYC_W        3
`define MITD_N1           3'h1
`define MITD_N2           3'h2
`define MITD_N3           3'h3
`define MITD_N4           3'h4
`define MITD_N5           3'h5
`define MITD_TAKEN_EXTRA  3'h1
`define MITD_BANK_LSB     3
`define MITD_BANK_MSB     4
`define MITD_SFR_BIT      7
`define MITD_PAGE_LSB     11
`define MITD_ONE          8'h01

`define MITD_OP_NOP       8'h00
`define MITD_OP_SPARE     8'hA5
`define MITD_OP_RR        8'h03
`define MITD_OP_RRC       8'h13
`define MITD_OP_RL        8'h23
`define MITD_OP_RLC       8'h33
`define MITD_OP_SWAP      8'hC4
`define MITD_OP_CLRA      8'hE4
`define MITD_OP_CPLA      8'hF4
`define MITD_OP_XOR_DA    8'h62
`define MITD_OP_XOR_DI    8'h63
`define MITD_OP_XOR_AI    8'h64
`define MITD_OP_XOR_AD    8'h65
`define MITD_OP_MOV_AI    8'h74
`define MITD_OP_MOV_DI    8'h75
`define MITD_OP_MOV_DD    8'h85
`define MITD_OP_MOV_DATA_POINTER  8'h90
`define MITD_OP_MOV_AD    8'hE5
`define MITD_OP_MOV_DA    8'hF5
`define MITD_OP_CODE_PC   8'h83
`define MITD_OP_CODE_DP   8'h93
`define MITD_OP_EXT_RD_DP 8'hE0
`define MITD_OP_EXT_WR_DP 8'hF0
`define MITD_OP_PUSH      8'hC0
`define MITD_OP_POP       8'hD0
`define MITD_OP_XCH_D     8'hC5
`define MITD_OP_CLRC      8'hC3
`define MITD_OP_SETC      8'hD3
`define MITD_OP_CPLC      8'hB3
`define MITD_OP_CLRB      8'hC2
`define MITD_OP_SETB      8'hD2
`define MITD_OP_CPLB      8'hB2
`define MITD_OP_ANL_CB    8'h82
`define MITD_OP_ANL_CNB   8'hB0
`define MITD_OP_ORL_CB    8'h72
`define MITD_OP_ORL_CNB   8'hA0
`define MITD_OP_MOV_CB    8'hA2
`define MITD_OP_MOV_BC    8'h92
`define MITD_OP_JC        8'h40
`define MITD_OP_JNC       8'h50
`define MITD_OP_JB        8'h20
`define MITD_OP_JNB       8'h30
`define MITD_OP_JBC       8'h10
`define MITD_OP_JZ        8'h60
`define MITD_OP_JNZ       8'h70
`define MITD_OP_FAR_CALL  8'h12
`define MITD_OP_FAR_JMP   8'h02
`define MITD_OP_RET       8'h22
`define MITD_OP_INTERRUPT_RETURN      8'h32
`define MITD_OP_SHORT_REL_JUMP      8'h80
`define MITD_OP_JMP_ADP   8'h73
`define MITD_OP_CMP_AD    8'hB5
`define MITD_OP_CMP_AI    8'hB4
`define MITD_OP_DEC_D     8'hD5
`define MITD_PAGE_JMP     5'h01
`define MITD_PAGE_CALL    5'h11

`endif

// ### include/mitd_pkg.sv
/*
 * Types of the instruction length and timing decoder.
 * Assumes mitd_defines.svh is on the include path.
 */
package mitd_pkg;

    typedef enum logic [2:0] {
        MODE_IMPLIED  = 3'b000,
        MODE_BANK     = 3'b001,
        MODE_INDIRECT = 3'b010,
        MODE_DIRECT   = 3'b011,
        MODE_BIT      = 3'b100,
        MODE_IMM16    = 3'b101,
        MODE_CODE     = 3'b110,
        MODE_EXT      = 3'b111
    } mitd_mode_e;

    typedef enum logic [3:0] {
        COND_NONE   = 4'b0000,
        COND_ALWAYS = 4'b0001,
        COND_CY     = 4'b0010,
        COND_NCY    = 4'b0011,
        COND_ZERO   = 4'b0100,
        COND_NZERO  = 4'b0101,
        COND_BIT    = 4'b0110,
        COND_NBIT   = 4'b0111,
        COND_NEQ    = 4'b1000,
        COND_DECNZ  = 4'b1001
    } mitd_cond_e;

    typedef enum logic [2:0] {
        TGT_NONE  = 3'b000,
        TGT_REL   = 3'b001,
        TGT_PAGE  = 3'b010,
        TGT_FAR   = 3'b011,
        TGT_ADPTR = 3'b100,
        TGT_APC   = 3'b101,
        TGT_STACK = 3'b110
    } mitd_tgt_e;

endpackage

// ### rtl/mitd_decoder.sv
/*
 * Instruction length and timing decoder for logical XOR, accumulator,
 * data transfer, boolean and program branching opcodes. One instruction
 * is presented per start_i pulse; results appear, registered, one cycle
 * later, and a new instruction may follow every cycle.
 * Assumes the datapath supplies the operand bytes, the bank bits of the
 * status word and the branch condition values in the same cycle.
 */
// Behaviour
// - XOR immediate or into direct: 2 bytes 2 cycles; immediate-to-direct 3/3.
// - Accumulator clear, complement, rotates, nibble swap: 1 byte, 1 cycle.
// - Accumulator/bank register moves 1 cycle; indirect RAM moves 2 cycles.
// - Direct-to-direct and immediate-to-direct moves 3/3; other direct moves 2/2.
// - Loading the data pointer with 16-bit constant: 3 bytes, 3 cycles.
// - Code byte read at accumulator plus data pointer or PC: 1 byte, 3 cycles.
// - External data moves, either address width: 1 byte, 3 cycles.
// - Stack push and pop of a direct byte: 2 bytes, 2 cycles.
// - Swap with bank register 1 cycle, direct/indirect 2; low-nibble swap 2.
// - Carry-only ops 1/1; direct bit operations 2 bytes 2 cycles.
// - Carry and accumulator-zero jumps: 2 bytes, 2 not taken, 3 taken.
// - Direct bit jumps 3 bytes, 3/4 cycles; test-and-clear clears bit when taken.
// - Short and page jumps 3 cycles; jump via A+pointer 1/3; returns 1/5.
// - Compare-branch 3 bytes 3/4; indirect form 4/5.
// - Decrement-branch: register 2 bytes 2/3, direct 3 bytes 3/4; taken if nonzero.
// - Relative offset is signed 8-bit, added to the next instruction address.
// - Direct-mode operand below 0x80 is data RAM, otherwise special registers.
// - Page targets keep upper bits of the next instruction address, 2K page.
// - Far call and jump take full 16-bit target; 3 bytes, 4 cycles.
// - No-operation and spare opcode 0xA5: 1 byte, 1 cycle.
// - Bank register in selected bank; indirect pointer is R0 or R1 only.
// - Conditional branches finish one cycle sooner when not taken.
// - Bank chosen by status word bits 3 and 4, four banks 0x00-0x1F.
// - Direct-mode operand above 0x7F reaches special registers, indirect reaches upper RAM.
`timescale 1ns/1ps
`include "mitd_defines.svh"

module mitd_decoder #(
    parameter int ADDR_W = 16
) (
    input  wire logic                   clk_sys_i,
    input  wire logic                   rst_i,
    input  wire logic                   start_i,
    input  wire logic [7:0]             opcode_i,
    input  wire logic [7:0]             byte1_i,
    input  wire logic [7:0]             byte2_i,
    input  wire logic [ADDR_W-1:0]      pc_i,
    input  wire logic [ADDR_W-1:0]      data_pointer_i,
    input  wire logic [7:0]             status_word_i,
    input  wire logic [7:0]             acc_i,
    input  wire logic                   carry_i,
    input  wire logic                   bit_value_i,
    input  wire logic [7:0]             cmp_left_i,
    input  wire logic [7:0]             cmp_right_i,
    output logic                        valid_o,
    output logic                        known_o,
    output logic [`MITD_LEN_W-1:0]      length_o,
    output logic [`MITD_CYC_W-1:0]      cycles_not_taken_o,
    output logic [`MITD_CYC_W-1:0]      cycles_taken_o,
    output logic [`MITD_CYC_W-1:0]      cycles_o,
    output logic                        conditional_o,
    output logic                        taken_o,
    output logic [2:0]                  mode_o,
    output logic [7:0]                  bank_reg_addr_o,
    output logic [7:0]                  pointer_reg_addr_o,
    output logic [7:0]                  direct_addr_o,
    output logic                        direct_sfr_o,
    output logic                        indirect_upper_ram_o,
    output logic                        target_valid_o,
    output logic [ADDR_W-1:0]           target_o,
    output logic                        low_nibble_swap_o,
    output logic                        clear_tested_bit_o,
    output logic                        no_operation_o
);

    logic [`MITD_LEN_W-1:0] len_nxt;
    logic [`MITD_CYC_W-1:0] cyc_nxt;
    logic                   known_nxt;
    logic                   rel_in_b2_nxt;
    logic                   nibble_nxt;
    logic                   nop_nxt;
    mitd_pkg::mitd_mode_e   mode_nxt;
    mitd_pkg::mitd_cond_e   cond_nxt;
    mitd_pkg::mitd_tgt_e    tgt_nxt;
    logic                   taken_nxt;
    logic [ADDR_W-1:0]      next_pc;
    logic [7:0]             rel_byte;
    logic [ADDR_W-1:0]      target_nxt;

    // Opcode table; low three bits select a bank register in the 0x?8 rows.
    always_comb begin
        len_nxt       = `MITD_N1;
        cyc_nxt       = `MITD_N1;
        known_nxt     = 1'b1;
        rel_in_b2_nxt = 1'b0;
        nibble_nxt    = 1'b0;
        nop_nxt       = 1'b0;
        mode_nxt      = mitd_pkg::MODE_IMPLIED;
        cond_nxt      = mitd_pkg::COND_NONE;
        tgt_nxt       = mitd_pkg::TGT_NONE;
        if (opcode_i[4:0] == `MITD_PAGE_JMP || opcode_i[4:0] == `MITD_PAGE_CALL) begin
            len_nxt = `MITD_N2;
            cyc_nxt = `MITD_N3;
            tgt_nxt = mitd_pkg::TGT_PAGE;
        end else if (opcode_i[3]) begin
            mode_nxt = mitd_pkg::MODE_BANK;
            case (opcode_i[7:4])
                4'h6, 4'hE, 4'hF, 4'hC: begin
                    len_nxt = `MITD_N1;
                    cyc_nxt = `MITD_N1;
                end
                4'h7, 4'h8, 4'hA: begin
                    len_nxt = `MITD_N2;
                    cyc_nxt = `MITD_N2;
                end
                4'hB: begin
                    len_nxt       = `MITD_N3;
                    cyc_nxt       = `MITD_N3;
                    cond_nxt      = mitd_pkg::COND_NEQ;
                    tgt_nxt       = mitd_pkg::TGT_REL;
                    rel_in_b2_nxt = 1'b1;
                end
                4'hD: begin
                    len_nxt  = `MITD_N2;
                    cyc_nxt  = `MITD_N2;
                    cond_nxt = mitd_pkg::COND_DECNZ;
                    tgt_nxt  = mitd_pkg::TGT_REL;
                end
                default: known_nxt = 1'b0;
            endcase
        end else if (opcode_i[3:1] == 3'b011) begin
            mode_nxt = mitd_pkg::MODE_INDIRECT;
            case (opcode_i[7:4])
                4'h6, 4'hE, 4'hF, 4'hC: begin
                    len_nxt = `MITD_N1;
                    cyc_nxt = `MITD_N2;
                end
                4'hD: begin
                    len_nxt    = `MITD_N1;
                    cyc_nxt    = `MITD_N2;
                    nibble_nxt = 1'b1;
                end
                4'h7, 4'h8, 4'hA: begin
                    len_nxt = `MITD_N2;
                    cyc_nxt = `MITD_N2;
                end
                4'hB: begin
                    len_nxt       = `MITD_N3;
                    cyc_nxt       = `MITD_N4;
                    cond_nxt      = mitd_pkg::COND_NEQ;
                    tgt_nxt       = mitd_pkg::TGT_REL;
                    rel_in_b2_nxt = 1'b1;
                end
                default: known_nxt = 1'b0;
            endcase
        end else if (opcode_i[7:5] == 3'b111 && opcode_i[3:1] == 3'b001) begin
            mode_nxt = mitd_pkg::MODE_EXT;
            len_nxt  = `MITD_N1;
            cyc_nxt  = `MITD_N3;
        end else begin
            case (opcode_i)
                `MITD_OP_NOP, `MITD_OP_SPARE: nop_nxt = 1'b1;
                `MITD_OP_RR, `MITD_OP_RRC, `MITD_OP_RL, `MITD_OP_RLC,
                `MITD_OP_SWAP, `MITD_OP_CLRA, `MITD_OP_CPLA: len_nxt = `MITD_N1;
                `MITD_OP_CLRC, `MITD_OP_SETC, `MITD_OP_CPLC: len_nxt = `MITD_N1;
                `MITD_OP_XOR_AI, `MITD_OP_MOV_AI: begin
                    len_nxt = `MITD_N2;
                    cyc_nxt = `MITD_N2;
                end
                `MITD_OP_XOR_DA, `MITD_OP_XOR_AD, `MITD_OP_MOV_AD, `MITD_OP_MOV_DA,
                `MITD_OP_PUSH, `MITD_OP_POP, `MITD_OP_XCH_D: begin
                    mode_nxt = mitd_pkg::MODE_DIRECT;
                    len_nxt  = `MITD_N2;
                    cyc_nxt  = `MITD_N2;
                end
                `MITD_OP_XOR_DI, `MITD_OP_MOV_DI, `MITD_OP_MOV_DD: begin
                    mode_nxt = mitd_pkg::MODE_DIRECT;
                    len_nxt  = `MITD_N3;
                    cyc_nxt  = `MITD_N3;
                end
                `MITD_OP_MOV_DATA_POINTER: begin
                    mode_nxt = mitd_pkg::MODE_IMM16;
                    len_nxt  = `MITD_N3;
                    cyc_nxt  = `MITD_N3;
                end
                `MITD_OP_CODE_DP, `MITD_OP_CODE_PC: begin
                    mode_nxt = mitd_pkg::MODE_CODE;
                    cyc_nxt  = `MITD_N3;
                    tgt_nxt  = opcode_i[4] ? mitd_pkg::TGT_ADPTR : mitd_pkg::TGT_APC;
                end
                `MITD_OP_EXT_RD_DP, `MITD_OP_EXT_WR_DP: begin
                    mode_nxt = mitd_pkg::MODE_EXT;
                    cyc_nxt  = `MITD_N3;
                end
                `MITD_OP_CLRB, `MITD_OP_SETB, `MITD_OP_CPLB, `MITD_OP_ANL_CB,
                `MITD_OP_ANL_CNB, `MITD_OP_ORL_CB, `MITD_OP_ORL_CNB,
                `MITD_OP_MOV_CB, `MITD_OP_MOV_BC: begin
                    mode_nxt = mitd_pkg::MODE_BIT;
                    len_nxt  = `MITD_N2;
                    cyc_nxt  = `MITD_N2;
                end
                `MITD_OP_JC, `MITD_OP_JNC, `MITD_OP_JZ, `MITD_OP_JNZ: begin
                    len_nxt = `MITD_N2;
                    cyc_nxt = `MITD_N2;
                    tgt_nxt = mitd_pkg::TGT_REL;
                    case (opcode_i)
                        `MITD_OP_JC:  cond_nxt = mitd_pkg::COND_CY;
                        `MITD_OP_JNC: cond_nxt = mitd_pkg::COND_NCY;
                        `MITD_OP_JZ:  cond_nxt = mitd_pkg::COND_ZERO;
                        default:      cond_nxt = mitd_pkg::COND_NZERO;
                    endcase
                end
                `MITD_OP_JB, `MITD_OP_JBC, `MITD_OP_JNB: begin
                    mode_nxt      = mitd_pkg::MODE_BIT;
                    len_nxt       = `MITD_N3;
                    cyc_nxt       = `MITD_N3;
                    tgt_nxt       = mitd_pkg::TGT_REL;
                    rel_in_b2_nxt = 1'b1;
                    cond_nxt      = (opcode_i == `MITD_OP_JNB) ? mitd_pkg::COND_NBIT
                                                               : mitd_pkg::COND_BIT;
                end
                `MITD_OP_CMP_AD, `MITD_OP_CMP_AI: begin
                    mode_nxt      = opcode_i[0] ? mitd_pkg::MODE_DIRECT
                                                : mitd_pkg::MODE_IMPLIED;
                    len_nxt       = `MITD_N3;
                    cyc_nxt       = `MITD_N3;
                    cond_nxt      = mitd_pkg::COND_NEQ;
                    tgt_nxt       = mitd_pkg::TGT_REL;
                    rel_in_b2_nxt = 1'b1;
                end
                `MITD_OP_DEC_D: begin
                    mode_nxt      = mitd_pkg::MODE_DIRECT;
                    len_nxt       = `MITD_N3;
                    cyc_nxt       = `MITD_N3;
                    cond_nxt      = mitd_pkg::COND_DECNZ;
                    tgt_nxt       = mitd_pkg::TGT_REL;
                    rel_in_b2_nxt = 1'b1;
                end
                `MITD_OP_SHORT_REL_JUMP: begin
                    len_nxt = `MITD_N2;
                    cyc_nxt = `MITD_N3;
                    tgt_nxt = mitd_pkg::TGT_REL;
                end
                `MITD_OP_JMP_ADP: begin
                    cyc_nxt = `MITD_N3;
                    tgt_nxt = mitd_pkg::TGT_ADPTR;
                end
                `MITD_OP_RET, `MITD_OP_INTERRUPT_RETURN: begin
                    cyc_nxt = `MITD_N5;
                    tgt_nxt = mitd_pkg::TGT_STACK;
                end
                `MITD_OP_FAR_CALL, `MITD_OP_FAR_JMP: begin
                    len_nxt = `MITD_N3;
                    cyc_nxt = `MITD_N4;
                    tgt_nxt = mitd_pkg::TGT_FAR;
                end
                default: known_nxt = 1'b0;
            endcase
        end
    end

    // Condition outcome from the datapath values presented with the opcode
    always_comb begin
        case (cond_nxt)
            mitd_pkg::COND_ALWAYS: taken_nxt = 1'b1;
            mitd_pkg::COND_CY:     taken_nxt = carry_i;
            mitd_pkg::COND_NCY:    taken_nxt = ~carry_i;
            mitd_pkg::COND_ZERO:   taken_nxt = (acc_i == 8'h00);
            mitd_pkg::COND_NZERO:  taken_nxt = (acc_i != 8'h00);
            mitd_pkg::COND_BIT:    taken_nxt = bit_value_i;
            mitd_pkg::COND_NBIT:   taken_nxt = ~bit_value_i;
            mitd_pkg::COND_NEQ:    taken_nxt = (cmp_left_i != cmp_right_i);
            // Decremented value is nonzero unless the operand was one
            mitd_pkg::COND_DECNZ:  taken_nxt = (cmp_left_i != `MITD_ONE);
            default:               taken_nxt = 1'b0;
        endcase
    end

    assign next_pc  = pc_i + ADDR_W'(len_nxt);
    assign rel_byte = rel_in_b2_nxt ? byte2_i : byte1_i;

    always_comb begin
        case (tgt_nxt)
            mitd_pkg::TGT_REL:
                target_nxt = next_pc + ADDR_W'({{8{rel_byte[7]}}, rel_byte});
            mitd_pkg::TGT_PAGE:
                target_nxt = {next_pc[ADDR_W-1:`MITD_PAGE_LSB], opcode_i[7:5], byte1_i};
            mitd_pkg::TGT_FAR:
                target_nxt = ADDR_W'({byte1_i, byte2_i});
            mitd_pkg::TGT_ADPTR:
                target_nxt = data_pointer_i + ADDR_W'(acc_i);
            mitd_pkg::TGT_APC:
                target_nxt = next_pc + ADDR_W'(acc_i);
            default:
                target_nxt = '0;
        endcase
    end

    // Result registers; a new instruction is taken every cycle, no idle gap
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            valid_o <= 1'b0;
        end else begin
            valid_o <= start_i;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            known_o            <= 1'b0;
            length_o           <= '0;
            cycles_not_taken_o <= '0;
            cycles_taken_o     <= '0;
            cycles_o           <= '0;
            conditional_o      <= 1'b0;
            taken_o            <= 1'b0;
            mode_o             <= mitd_pkg::MODE_IMPLIED;
            no_operation_o     <= 1'b0;
            low_nibble_swap_o  <= 1'b0;
            clear_tested_bit_o <= 1'b0;
        end else if (start_i) begin
            known_o            <= known_nxt;
            length_o           <= len_nxt;
            cycles_not_taken_o <= cyc_nxt;
            conditional_o      <= (cond_nxt != mitd_pkg::COND_NONE);
            mode_o             <= mode_nxt;
            no_operation_o     <= nop_nxt;
            low_nibble_swap_o  <= nibble_nxt;
            clear_tested_bit_o <= (opcode_i == `MITD_OP_JBC) && taken_nxt;
            taken_o            <= taken_nxt;
            cycles_taken_o     <= cyc_nxt + ((cond_nxt != mitd_pkg::COND_NONE)
                                  ? `MITD_TAKEN_EXTRA : 3'h0);
            cycles_o           <= cyc_nxt + (taken_nxt ? `MITD_TAKEN_EXTRA : 3'h0);
        end
    end

    // Operand addresses; indirect accesses never reach the special registers
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            bank_reg_addr_o      <= '0;
            pointer_reg_addr_o   <= '0;
            direct_addr_o        <= '0;
            direct_sfr_o         <= 1'b0;
            indirect_upper_ram_o <= 1'b0;
        end else if (start_i) begin
            bank_reg_addr_o    <= {3'h0, status_word_i[`MITD_BANK_MSB:`MITD_BANK_LSB],
                                   opcode_i[2:0]};
            pointer_reg_addr_o <= {3'h0, status_word_i[`MITD_BANK_MSB:`MITD_BANK_LSB],
                                   2'h0, opcode_i[0]};
            direct_addr_o      <= byte1_i;
            direct_sfr_o       <= (mode_nxt == mitd_pkg::MODE_DIRECT)
                                  && byte1_i[`MITD_SFR_BIT];
            indirect_upper_ram_o <= (mode_nxt == mitd_pkg::MODE_INDIRECT);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            target_valid_o <= 1'b0;
            target_o       <= '0;
        end else if (start_i) begin
            target_valid_o <= (tgt_nxt != mitd_pkg::TGT_NONE)
                              && (tgt_nxt != mitd_pkg::TGT_STACK);
            target_o       <= target_nxt;
        end
    end

endmodule // mitd_decoder

// ### tb/mitd_chk.sv
/* Port checker of the instruction length and timing decoder.
   Assumes it is bound into mitd_decoder by the bind below. */
`timescale 1ns/1ps
module mitd_chk (
    input wire logic       clk_sys_i,
    input wire logic       rst_i,
    input wire logic       start_i,
    input wire logic [7:0] opcode_i,
    input wire logic [7:0] byte1_i,
    input wire logic [7:0] status_word_i,
    input wire logic       valid_o,
    input wire logic       conditional_o,
    input wire logic       taken_o,
    input wire logic [2:0] cycles_not_taken_o,
    input wire logic [2:0] cycles_taken_o,
    input wire logic [2:0] cycles_o,
    input wire logic       no_operation_o,
    input wire logic [7:0] bank_reg_addr_o,
    input wire logic       direct_sfr_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence req_s(logic [7:0] op); start_i && opcode_i == op; endsequence
    valid_pulse_a: assert property (start_i |=> valid_o) else $error("no result");
    valid_idle_a: assert property (!start_i |=> !valid_o) else $error("stray result");
    taken_extra_a: assert property (valid_o && conditional_o |->
        cycles_taken_o == cycles_not_taken_o + 3'h1) else $error("taken count");
    uncond_same_a: assert property (valid_o && !conditional_o |-> !taken_o &&
        cycles_taken_o == cycles_not_taken_o) else $error("fixed count");
    cycle_pick_a: assert property (valid_o |->
        cycles_o == (taken_o ? cycles_taken_o : cycles_not_taken_o)) else $error("pick");
    spare_nop_a: assert property (req_s(8'hA5) |=> no_operation_o && cycles_o == 3'h1)
        else $error("spare opcode");
    bank_addr_a: assert property (req_s(8'hED) ##0 status_word_i == 8'h18 |=>
        bank_reg_addr_o == 8'h1D) else $error("bank address");
    direct_sfr_a: assert property (req_s(8'hE5) |=>
        direct_sfr_o == ($past(byte1_i) > 8'h7F)) else $error("direct space");
endmodule // mitd_chk
bind mitd_decoder mitd_chk i_chk (.clk_sys_i, .rst_i, .start_i, .opcode_i, .byte1_i,
    .status_word_i, .valid_o, .conditional_o, .taken_o, .cycles_not_taken_o, .cycles_taken_o,
    .cycles_o, .no_operation_o, .bank_reg_addr_o, .direct_sfr_o);

// ### tb/tb_top.sv
/* Self-checking bench of the decoder: timing table, branches, operand fields.
   Assumes the checker is bound in from its own file. */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, carry_i = 1'b0, target_valid_o;
    logic        bit_value_i = 1'b0, valid_o, known_o, conditional_o, taken_o, direct_sfr_o;
    logic        indirect_upper_ram_o, low_nibble_swap_o, clear_tested_bit_o, no_operation_o;
    logic [7:0]  opcode_i = 8'h00, byte1_i = 8'h00, byte2_i = 8'h00, status_word_i = 8'h00;
    logic [7:0]  cmp_left_i = 8'h00, bank_reg_addr_o, pointer_reg_addr_o, direct_addr_o;
    logic [15:0] pc_i = 16'h0000, target_o;
    logic [2:0]  length_o, cycles_not_taken_o, cycles_taken_o, cycles_o, mode_o;
    int          bad_count = 0, cmp_count = 0, cyc_n = 0;
    // Accumulator 0x10 is nonzero, so the zero jump is refused and its opposite taken
    mitd_decoder i_dut (.clk_sys_i, .rst_i, .start_i, .opcode_i, .byte1_i, .byte2_i, .pc_i,
        .data_pointer_i(16'h4000), .status_word_i, .acc_i(8'h10), .carry_i, .bit_value_i,
        .cmp_left_i, .cmp_right_i(8'h33), .valid_o, .known_o, .length_o, .cycles_not_taken_o,
        .cycles_taken_o, .cycles_o, .conditional_o, .taken_o, .mode_o, .bank_reg_addr_o,
        .pointer_reg_addr_o, .direct_addr_o, .direct_sfr_o, .indirect_upper_ram_o,
        .target_valid_o, .target_o, .low_nibble_swap_o, .clear_tested_bit_o, .no_operation_o);
    always #5 clk_sys_i = ~clk_sys_i;
    task automatic final_report(input int extra);
        bad_count += extra;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 1000) final_report(1);
    end
    task automatic run(input logic [7:0] op, b1, b2, input logic [15:0] pc,
                       input logic [1:0] cb, input logic [7:0] l, st);
        @(posedge clk_sys_i);
        {opcode_i, byte1_i, byte2_i, pc_i, carry_i, bit_value_i, cmp_left_i, status_word_i,
            start_i} <= {op, b1, b2, pc, cb, l, st, 1'b1};
        @(posedge clk_sys_i);
        start_i <= 1'b0;
        #1;
    endtask
    task automatic t_table;
        logic [15:0] tab [$] = '{16'h6422, 16'h6522, 16'h6333, 16'hE411, 16'hF411, 16'h2311,
            16'h3311, 16'h0311, 16'h1311, 16'hC411, 16'hE811, 16'hE612, 16'hF612, 16'h8533,
            16'h7533, 16'hE522, 16'hA822, 16'h9033, 16'h9313, 16'h8313, 16'hE013, 16'hF213,
            16'hC022, 16'hD022, 16'hC811, 16'hC522, 16'hC612, 16'hD612, 16'hC311, 16'hD311,
            16'hB311, 16'hC222, 16'hB022, 16'h9222, 16'h8023, 16'h7313, 16'h2215, 16'h3215,
            16'h0123, 16'h1123, 16'h0234, 16'h1234, 16'h0011, 16'hA511};
        foreach (tab[i]) begin
            run(tab[i][15:8], 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h00);
            `CHK(length_o, tab[i][6:4])
            `CHK(cycles_o, tab[i][2:0])
            `CHK(valid_o, 1'b1)
            `CHK(known_o, 1'b1)
        end
        $display("table test done");
    endtask
    task automatic t_branch;
        // Fields: opcode, byte1, byte2, pc, carry and bit, left operand, length, cycles
        logic [59:0] br [$] = '{60'h40_05_00_0100_2_00_2_3, 60'h40_05_00_0100_0_00_2_2,
            60'h50_05_00_0100_0_00_2_3, 60'h60_05_00_0100_0_00_2_2, 60'h70_05_00_0100_0_00_2_3,
            60'h20_20_F0_0200_1_00_3_4, 60'h30_20_F0_0200_1_00_3_3, 60'hB7_00_10_0100_0_44_3_5,
            60'hB4_33_10_0100_0_33_3_3, 60'hBB_33_10_0100_0_44_3_4, 60'hD8_05_00_0100_0_01_2_2,
            60'hD5_30_02_0100_0_05_3_4, 60'h10_20_F0_0200_1_00_3_4};
        foreach (br[i]) begin
            run(br[i][59:52], br[i][51:44], br[i][43:36], br[i][35:20], br[i][17:16],
                br[i][15:8], 8'h00);
            `CHK(length_o, br[i][6:4])
            `CHK(cycles_o, br[i][2:0])
        end
        // The last row is the test-and-clear jump with a backward offset
        `CHK(target_o, 16'h01F3)
        `CHK(clear_tested_bit_o, 1'b1)
        $display("branch test done");
    endtask
    task automatic t_fields;
        run(8'h21, 8'h34, 8'h00, 16'h17FE, 2'b00, 8'h00, 8'h00);
        `CHK(target_o, 16'h1934)
        run(8'h02, 8'h12, 8'h34, 16'h0100, 2'b00, 8'h00, 8'h00);
        `CHK(target_o, 16'h1234)
        `CHK(target_valid_o, 1'b1)
        run(8'hED, 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h18);
        `CHK(bank_reg_addr_o, 8'h1D)
        `CHK(mode_o, 3'h1)
        run(8'hE7, 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h08);
        `CHK(pointer_reg_addr_o, 8'h09)
        `CHK(indirect_upper_ram_o, 1'b1)
        `CHK(mode_o, 3'h2)
        run(8'hE5, 8'h80, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h00);
        `CHK(direct_sfr_o, 1'b1)
        `CHK(direct_addr_o, 8'h80)
        `CHK(target_valid_o, 1'b0)
        run(8'h73, 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h00);
        `CHK(target_o, 16'h4010)
        run(8'h83, 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h00);
        `CHK(target_o, 16'h0111)
        run(8'h08, 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h00);
        `CHK(known_o, 1'b0)
        `CHK(length_o, 3'h1)
        run(8'hD7, 8'h00, 8'h00, 16'h0100, 2'b00, 8'h00, 8'h00);
        `CHK(low_nibble_swap_o, 1'b1)
        $display("field test done");
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_table();
        t_branch();
        t_fields();
        final_report(0);
    end
endmodule // tb_top
